// [inc/oc_mode_defs.svh]
/*
 Offsets, field positions, reset values and timing counts of the
 channel one/two output compare mode control block.
 Assumes inclusion by bare name from files that need the constants.
*/
`ifndef OC_MODE_DEFS_SVH
`define OC_MODE_DEFS_SVH

`define MODE_CTL_OFFSET 8'h18
`define CCR1_OFFSET 8'h34
`define CCR2_OFFSET 8'h38
`define MODE_CTL_RESET 16'h0000
`define CH2_SEL_HI 9
`define CH2_SEL_LO 8
`define CH1_CLR_BIT 7
`define CH1_MODE_HI 6
`define CH1_MODE_LO 4
`define CH1_PRE_BIT 3
`define CH1_FAST_BIT 2
`define CH2_CLR_BIT 15
`define CH2_MODE_HI 14
`define CH2_MODE_LO 12
`define CH2_PRE_BIT 11
`define CH2_FAST_BIT 10
`define LOCK_FULL 2'h3
`define SEL_OUTPUT 2'h0
`define TRIG_DELAY_SLOW 5
`define TRIG_DELAY_FAST 3

`endif

// [inc/oc_mode_pkg.sv]
/*
 Types shared by the output compare mode control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package oc_mode_pkg;
   typedef enum logic [2:0] {
      oc_frozen = 3'h0,
      oc_set = 3'h1,
      oc_clear = 3'h2,
      oc_toggle = 3'h3,
      oc_force_low = 3'h4,
      oc_force_high = 3'h5,
      oc_pwm_one = 3'h6,
      oc_pwm_two = 3'h7
   } oc_mode_e;
   typedef enum logic [1:0] {
      sel_output = 2'h0,
      sel_input_direct = 2'h1,
      sel_input_alt = 2'h2,
      sel_input_trc = 2'h3
   } dir_sel_e;
endpackage

// [hdl/oc_mode_ctl.sv]
/*
 Output compare mode control for channels 1 and 2 of a general timer:
 mode register, compare preload, reference waveform generation, trigger
 fast path and channel 2 input routing.
 Assumes a counter, update event and trigger from the surrounding timer,
 all synchronous to core_clk, and a single-cycle register port.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "oc_mode_defs.svh"

// Function
// - Channel 2 select field writable only while channel 2 enable is clear.
// - Select 00 is output; 01 and 10 route channel 2 timer input.
// - Select 11 routes internal trigger signal when internal source chosen.
// - Clear enable forces reference low while filtered external trigger high.
// - Active-high reference drives main and complementary outputs via polarity.
// - Mode 000 holds the reference level unchanged.
// - Mode 001 sets reference high on compare match.
// - Mode 010 clears reference low on compare match.
// - Mode 011 toggles reference on every compare match.
// - Mode 100 forces low, mode 101 forces high, regardless of compare match.
// - PWM one: up high below compare; down low above compare.
// - PWM two: up low below compare; down high above compare.
// - PWM reference follows the compare result in every cycle without a forcing trigger edge or clear, whatever mode preceded it.
// - Channel 1 mode field locked when lock level 11 and channel 1 is output.
// - Preload on: compare writes go to shadow, loaded on update event.
// - Channel 1 preload enable bit locked when lock level 11 and channel 1 output.
// - Fast enable in PWM shortens trigger-to-output delay.
// - Channel 2 fields at 15, 14:12, 11, 10 mirror channel 1.
// - In PWM modes a trigger edge forces the reference high in PWM one and low in PWM two, with or without fast enable.
// - Trigger-to-output delay is 5 cycles slow, 3 cycles fast.
module oc_mode_ctl
#(
   parameter int CNT_W = 16
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [CNT_W-1:0] counter_value,
   input wire logic count_down,
   input wire logic update_event,
   input wire logic trigger_in,
   input wire logic filtered_external_trigger,
   input wire logic ch1_channel_enable,
   input wire logic ch2_channel_enable,
   input wire logic ch1_main_polarity,
   input wire logic ch1_complementary_polarity,
   input wire logic ch2_main_polarity,
   input wire logic [1:0] lock_level,
   input wire logic [1:0] ch1_direction_select,
   input wire logic trigger_source_internal,
   input wire logic ch2_timer_input,
   input wire logic internal_trigger_selection_signal,
   output logic ch2_capture_input,
   output logic ch1_compare_reference,
   output logic ch2_compare_reference,
   output logic ch1_main_output,
   output logic ch1_complementary_output,
   output logic ch2_main_output,
   output oc_mode_pkg::dir_sel_e ch2_direction_select
);
   import oc_mode_pkg::*;

   logic [15:0] mode_ctl;
   logic [CNT_W-1:0] ccr_active [2];
   logic [CNT_W-1:0] ccr_shadow [2];
   logic ref_q [2];
   logic trig_q;
   logic trig_edge;
   logic [`TRIG_DELAY_SLOW-1:0] trig_pipe;
   logic locked;
   logic wr_mode;
   logic [15:0] next_mode_ctl;
   logic [1:0] ch_ref;
   oc_mode_e ch_mode [2];
   logic ch_pre [2];
   logic ch_fast [2];
   logic ch_clr [2];

   function automatic logic is_pwm(input oc_mode_e m);
      is_pwm = (m == oc_pwm_one) || (m == oc_pwm_two);
   endfunction

   // Level the PWM modes settle to for a given compare state
   function automatic logic pwm_level(input oc_mode_e m,
                                      input logic down,
                                      input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] cmp);
      logic lvl;
      lvl = 1'b0;
      if (!down)
         lvl = (cnt < cmp);
      else
         lvl = !(cnt > cmp);
      pwm_level = (m == oc_pwm_one) ? lvl : !lvl;
   endfunction

   assign ch_mode[0] = oc_mode_e'(mode_ctl[`CH1_MODE_HI:`CH1_MODE_LO]);
   assign ch_mode[1] = oc_mode_e'(mode_ctl[`CH2_MODE_HI:`CH2_MODE_LO]);
   assign ch_pre[0] = mode_ctl[`CH1_PRE_BIT];
   assign ch_pre[1] = mode_ctl[`CH2_PRE_BIT];
   assign ch_fast[0] = mode_ctl[`CH1_FAST_BIT];
   assign ch_fast[1] = mode_ctl[`CH2_FAST_BIT];
   assign ch_clr[0] = mode_ctl[`CH1_CLR_BIT];
   assign ch_clr[1] = mode_ctl[`CH2_CLR_BIT];
   assign ch2_direction_select =
      dir_sel_e'(mode_ctl[`CH2_SEL_HI:`CH2_SEL_LO]);

   assign locked = (lock_level == `LOCK_FULL) &&
                   (ch1_direction_select == `SEL_OUTPUT);
   assign wr_mode = reg_write && (reg_addr == `MODE_CTL_OFFSET);

   always_comb
   begin
      next_mode_ctl = reg_wdata[15:0];
      if (ch2_channel_enable)
         next_mode_ctl[`CH2_SEL_HI:`CH2_SEL_LO] =
            mode_ctl[`CH2_SEL_HI:`CH2_SEL_LO];
      if (locked)
      begin
         next_mode_ctl[`CH1_MODE_HI:`CH1_MODE_LO] =
            mode_ctl[`CH1_MODE_HI:`CH1_MODE_LO];
         next_mode_ctl[`CH1_PRE_BIT] = mode_ctl[`CH1_PRE_BIT];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         mode_ctl <= `MODE_CTL_RESET;
      else if (wr_mode)
         mode_ctl <= next_mode_ctl;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         reg_rdata <= 32'h0;
      else if (reg_read)
      begin
         case (reg_addr)
            `MODE_CTL_OFFSET: reg_rdata <= {16'h0, mode_ctl};
            `CCR1_OFFSET: reg_rdata <= 32'(ccr_shadow[0]);
            `CCR2_OFFSET: reg_rdata <= 32'(ccr_shadow[1]);
            default: reg_rdata <= 32'h0;
         endcase
      end
      else
         reg_rdata <= 32'h0;
   end

   // Channel 2 capture routing; 01 and 10 both take the direct input
   always_comb
   begin
      case (ch2_direction_select)
         sel_input_direct,
         sel_input_alt: ch2_capture_input = ch2_timer_input;
         sel_input_trc: ch2_capture_input =
            trigger_source_internal &&
            internal_trigger_selection_signal;
         default: ch2_capture_input = 1'b0;
      endcase
   end

   // Trigger edge pipe; the slow path taps the fourth of five stages, fast path
   // taps earlier so the output reacts two cycles sooner
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         trig_q <= 1'b0;
         trig_pipe <= '0;
      end
      else
      begin
         trig_q <= trigger_in;
         trig_pipe <= {trig_pipe[`TRIG_DELAY_SLOW-2:0], trig_edge};
      end
   end
   assign trig_edge = trigger_in && !trig_q;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_ch
         logic match;
         logic fast_hit;
         logic next_ref;
         logic wr_ccr;
         assign wr_ccr = reg_write &&
            (reg_addr == (ch == 0 ? `CCR1_OFFSET : `CCR2_OFFSET));
         // Shadow holds the last write; active follows it at once
         // without preload, otherwise only on an update event
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
               ccr_shadow[ch] <= '0;
            else if (wr_ccr)
               ccr_shadow[ch] <= reg_wdata[CNT_W-1:0];
         end
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
               ccr_active[ch] <= '0;
            else if (wr_ccr && !ch_pre[ch])
               ccr_active[ch] <= reg_wdata[CNT_W-1:0];
            else if (update_event && ch_pre[ch])
               ccr_active[ch] <= ccr_shadow[ch];
         end
         assign match = (counter_value == ccr_active[ch]);
         // Stage 2 reaches the output at edge 3, stage 4 at edge 5
         assign fast_hit = is_pwm(ch_mode[ch]) && (ch_fast[ch] ?
            trig_pipe[`TRIG_DELAY_FAST-2] :
            trig_pipe[`TRIG_DELAY_SLOW-2]);
         always_comb
         begin
            next_ref = ref_q[ch];
            case (ch_mode[ch])
               oc_frozen: next_ref = ref_q[ch];
               oc_set: if (match) next_ref = 1'b1;
               oc_clear: if (match) next_ref = 1'b0;
               oc_toggle: if (match) next_ref = !ref_q[ch];
               oc_force_low: next_ref = 1'b0;
               oc_force_high: next_ref = 1'b1;
               oc_pwm_one,
               oc_pwm_two: next_ref = pwm_level(ch_mode[ch], count_down,
                  counter_value, ccr_active[ch]);
               default: next_ref = ref_q[ch];
            endcase
            if (fast_hit)
               next_ref = (ch_mode[ch] == oc_pwm_one);
            if (ch_clr[ch] && filtered_external_trigger)
               next_ref = 1'b0;
         end
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
               ref_q[ch] <= 1'b0;
            else
               ref_q[ch] <= next_ref;
         end
         assign ch_ref[ch] = ref_q[ch];
      end
   endgenerate

   assign ch1_compare_reference = ch_ref[0];
   assign ch2_compare_reference = ch_ref[1];
   // Polarity only inverts; the reference itself stays active high
   assign ch1_main_output = ch_ref[0] ^ ch1_main_polarity;
   assign ch1_complementary_output =
      !ch_ref[0] ^ ch1_complementary_polarity;
   assign ch2_main_output = ch_ref[1] ^ ch2_main_polarity;

   ch2_sel_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch2_channel_enable && wr_mode |=>
      $stable(ch2_direction_select))
      else $error("channel 2 select changed while enabled");
   ch1_mode_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
      locked && wr_mode |=> $stable(ch_mode[0]))
      else $error("channel 1 mode changed while locked");
   ch1_pre_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
      locked && wr_mode |=> $stable(ch_pre[0]))
      else $error("channel 1 preload changed while locked");
   ref_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_clr[0] && filtered_external_trigger |=>
      !ch1_compare_reference)
      else $error("reference not cleared by external trigger");
   force_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_force_low ##1
      ch_mode[0] == oc_force_low |-> !ch1_compare_reference)
      else $error("forced low mode not low");
   frozen_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_frozen && !(ch_clr[0] && filtered_external_trigger)
      |=> $stable(ch1_compare_reference))
      else $error("frozen reference moved");
   set_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_set && counter_value == ccr_active[0] &&
      !(ch_clr[0] && filtered_external_trigger) |=>
      ch1_compare_reference)
      else $error("set on match failed");
   toggle_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_toggle && counter_value == ccr_active[0] &&
      !(ch_clr[0] && filtered_external_trigger) |=>
      ch1_compare_reference != $past(ch1_compare_reference))
      else $error("toggle on match failed");
   preload_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_pre[0] && !update_event && !reg_write |=>
      $stable(ccr_active[0]))
      else $error("active compare moved without update");
   fast_delay_a: assert property (@(posedge core_clk) disable iff (!nrst)
      trig_edge && ch_fast[0] && ch_mode[0] == oc_pwm_one ##1
      (ch_fast[0] && ch_mode[0] == oc_pwm_one &&
      !(ch_clr[0] && filtered_external_trigger)) [*3] |->
      ch1_compare_reference)
      else $error("fast trigger response late");
   upper_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $past(reg_read) |-> reg_rdata[31:16] == 16'h0)
      else $error("upper mode bits not zero");
   clear_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_clear && counter_value == ccr_active[0] |=>
      !ch1_compare_reference)
      else $error("clear on match failed");
   force_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_force_high && !(ch_clr[0] && filtered_external_trigger)
      |=> ch1_compare_reference)
      else $error("forced high mode not high");
   pwm_one_up_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_pwm_one && !count_down && !g_ch[0].fast_hit &&
      counter_value < ccr_active[0] &&
      !(ch_clr[0] && filtered_external_trigger) |=>
      ch1_compare_reference)
      else $error("first PWM mode not high below compare");
   pwm_one_down_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_pwm_one && count_down && !g_ch[0].fast_hit &&
      counter_value > ccr_active[0] |=> !ch1_compare_reference)
      else $error("first PWM mode not low above compare");
   pwm_two_up_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_pwm_two && !count_down &&
      counter_value < ccr_active[0] |=> !ch1_compare_reference)
      else $error("second PWM mode not low below compare");
   pwm_two_down_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[0] == oc_pwm_two && count_down && !g_ch[0].fast_hit &&
      counter_value > ccr_active[0] &&
      !(ch_clr[0] && filtered_external_trigger) |=>
      ch1_compare_reference)
      else $error("second PWM mode not high above compare");
   slow_delay_a: assert property (@(posedge core_clk) disable iff (!nrst)
      trig_edge && !ch_fast[0] && ch_mode[0] == oc_pwm_one ##1
      (!ch_fast[0] && ch_mode[0] == oc_pwm_one &&
      !(ch_clr[0] && filtered_external_trigger)) [*5] |->
      ch1_compare_reference)
      else $error("slow trigger response late");
   ch1_outputs_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch1_main_output == (ch1_compare_reference ^ ch1_main_polarity) &&
      ch1_complementary_output ==
      (!ch1_compare_reference ^ ch1_complementary_polarity))
      else $error("channel 1 outputs disagree with reference");
   cap_direct_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (ch2_direction_select == sel_input_direct ||
      ch2_direction_select == sel_input_alt) |->
      ch2_capture_input == ch2_timer_input)
      else $error("channel 2 capture not from timer input");
   cap_trc_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch2_direction_select == sel_input_trc |-> ch2_capture_input ==
      (trigger_source_internal && internal_trigger_selection_signal))
      else $error("channel 2 capture not from internal trigger");
   ch2_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_mode[1] == oc_force_high && !(ch_clr[1] && filtered_external_trigger)
      |=> ch2_compare_reference)
      else $error("channel 2 forced high mode not high");
   ch2_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_clr[1] && filtered_external_trigger |=>
      !ch2_compare_reference)
      else $error("channel 2 reference not cleared");
   ch2_pre_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_pre[1] && !update_event && !reg_write |=>
      $stable(ccr_active[1]))
      else $error("channel 2 active compare moved without update");
   write_lands_a: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_mode && !locked && !ch2_channel_enable |=>
      {16'h0, mode_ctl} == ($past(reg_wdata) & 32'h0000_ffff))
      else $error("mode register write lost");
   update_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ch_pre[0] && update_event |=>
      ccr_active[0] == $past(ccr_shadow[0]))
      else $error("update event did not load shadow compare");
endmodule

// [tb/test_timer_output_compare_mode_ctl.sv]
/*
 Self-checking bench for the channel one/two output compare mode block.
 Assumes the package, the constants header and the design are compiled
 first; the design's assertions stay active during the run.
*/
`timescale 1ns/100ps
`include "oc_mode_defs.svh"
module test_timer_output_compare_mode_ctl;
   import oc_mode_pkg::*;
   logic core_clk = '0;
   logic nrst = '0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_write = '0;
   logic reg_read = '0;
   logic [31:0] reg_rdata;
   logic [15:0] counter_value = '0;
   logic count_down = '0;
   logic update_event = '0;
   logic trigger_in = '0;
   logic filtered_external_trigger = '0;
   logic ch1_channel_enable = '0;
   logic ch2_channel_enable = '0;
   logic ch1_main_polarity = '0;
   logic ch1_complementary_polarity = '0;
   logic ch2_main_polarity = '0;
   logic [1:0] lock_level = '0;
   logic [1:0] ch1_direction_select = '0;
   logic trigger_source_internal = '0;
   logic ch2_timer_input = '0;
   logic internal_trigger_selection_signal = '0;
   logic ch2_capture_input, ch1_compare_reference, ch2_compare_reference;
   logic ch1_main_output, ch1_complementary_output, ch2_main_output;
   dir_sel_e ch2_direction_select;
   logic look = '0;
   logic rd_d = '0;
   logic [63:0] exp_q [$];
   logic [31:0] rnd;
   integer seed = 32'h4716;
   int bad_count = 0;
   int check_count = 0;
   // Columns: mode word, counter, {down, ext trigger, ref1, ref2}
   logic [35:0] tbl [17] = '{36'h5050_0020_3, 36'h0000_0010_3,
      36'h4040_0010_0, 36'h0010_0020_0, 36'h0010_0010_2, 36'h0020_0010_0,
      36'h80d0_0010_4, 36'h00d0_0010_2, 36'h0068_000f_2, 36'h0068_0010_0,
      36'h0068_0011_8, 36'h0068_0010_a, 36'h0078_000f_0, 36'h0078_0011_a,
      36'h0078_0010_8, 36'h0040_0020_0, 36'h0030_0020_0};

   oc_mode_ctl #(.CNT_W(16)) dut (.core_clk, .nrst, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .counter_value, .count_down,
      .update_event, .trigger_in, .filtered_external_trigger,
      .ch1_channel_enable, .ch2_channel_enable, .ch1_main_polarity,
      .ch1_complementary_polarity, .ch2_main_polarity, .lock_level,
      .ch1_direction_select, .trigger_source_internal, .ch2_timer_input,
      .internal_trigger_selection_signal, .ch2_capture_input,
      .ch1_compare_reference, .ch2_compare_reference, .ch1_main_output,
      .ch1_complementary_output, .ch2_main_output, .ch2_direction_select);

   initial
   begin
      forever #25 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Each bus task leaves an idle edge so no strobe is assigned twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge core_clk);
      reg_write <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back({32'hffff_ffff, e});
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge core_clk);
      reg_read <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic look_at(input logic [7:0] m, input logic [7:0] e);
      exp_q.push_back({24'h0, m, 24'h0, e & m});
      look <= 1'h1;
      @(posedge core_clk);
      look <= 1'h0;
      @(posedge core_clk);
   endtask

   function automatic logic [7:0] refs(input logic a, input logic b);
      return {3'h0, b ^ ch2_main_polarity, ~a ^ ch1_complementary_polarity,
         a ^ ch1_main_polarity, b, a};
   endfunction

   // Read data stands only in the cycle after the strobe
   always @(posedge core_clk)
   begin
      logic [63:0] n;
      if (rd_d)
      begin
         n = exp_q.pop_front();
         check(reg_rdata & n[63:32], n[31:0]);
      end
      if (look)
      begin
         n = exp_q.pop_front();
         check({24'h0, ch2_direction_select, ch2_capture_input,
            ch2_main_output, ch1_complementary_output, ch1_main_output,
            ch2_compare_reference, ch1_compare_reference} & n[63:32],
            n[31:0]);
      end
      rd_d <= reg_read;
   end

   initial
   begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'h1;
      rd(`MODE_CTL_OFFSET, 32'h0);
      wr(`MODE_CTL_OFFSET, 32'hffff_ffff);
      rd(`MODE_CTL_OFFSET, 32'h0000_ffff);
      rd(8'h1c, 32'h0);
      ch2_channel_enable <= 1'h1;
      wr(`MODE_CTL_OFFSET, 32'h0);
      rd(`MODE_CTL_OFFSET, 32'h0000_0300);
      ch2_channel_enable <= 1'h0;
      for (int s = 0; s < 4; s++)
      begin
         wr(`MODE_CTL_OFFSET, {22'h0, s[1:0], 8'h0});
         rnd = $random(seed);
         {ch2_timer_input, internal_trigger_selection_signal,
            trigger_source_internal} <= rnd[2:0];
         repeat (2) @(posedge core_clk);
         look_at(s == 0 ? 8'hc0 : 8'he0, {s[1:0], s == 3 ?
            internal_trigger_selection_signal & trigger_source_internal :
            ch2_timer_input, 5'h0});
      end
      wr(`CCR1_OFFSET, 32'h10);
      // Inputs settle before the mode write so no stray match is seen
      for (int i = 0; i < 17; i++)
      begin
         rnd = $random(seed);
         {ch1_main_polarity, ch1_complementary_polarity,
            ch2_main_polarity} <= rnd[2:0];
         counter_value <= tbl[i][19:4];
         {count_down, filtered_external_trigger} <= tbl[i][3:2];
         wr(`MODE_CTL_OFFSET, {16'h0, tbl[i][35:20]});
         repeat (3) @(posedge core_clk);
         look_at(8'h3f, refs(tbl[i][1],
            tbl[i][0]));
      end
      for (int i = 0; i < 2; i++)
      begin
         counter_value <= 16'h10;
         @(posedge core_clk);
         counter_value <= 16'h20;
         repeat (3) @(posedge core_clk);
         look_at(8'h01, {7'h0, i == 0});
      end
      wr(`MODE_CTL_OFFSET, 32'h68);
      wr(`CCR1_OFFSET, 32'h30);
      repeat (2) @(posedge core_clk);
      look_at(8'h01, 8'h0);
      rd(`CCR1_OFFSET, 32'h30);
      update_event <= 1'h1;
      @(posedge core_clk);
      update_event <= 1'h0;
      repeat (3) @(posedge core_clk);
      look_at(8'h01, 8'h1);
      lock_level <= 2'h3;
      wr(`MODE_CTL_OFFSET, 32'h58);
      rd(`MODE_CTL_OFFSET, 32'h68);
      ch1_direction_select <= 2'h1;
      wr(`MODE_CTL_OFFSET, 32'h50);
      rd(`MODE_CTL_OFFSET, 32'h50);
      lock_level <= 2'h0;
      ch1_direction_select <= 2'h0;
      counter_value <= 16'h40;
      for (int f = 0; f < 2; f++)
      begin
         wr(`MODE_CTL_OFFSET, f == 1 ? 32'h6c : 32'h68);
         repeat (2) @(posedge core_clk);
         trigger_in <= 1'h1;
         // First look sees the level just before the forced change
         repeat (f == 1 ? `TRIG_DELAY_FAST - 1 : `TRIG_DELAY_SLOW - 1)
            @(posedge core_clk);
         exp_q.push_back(64'h1_0000_0000);
         exp_q.push_back(64'h1_0000_0001);
         look <= 1'h1;
         repeat (2) @(posedge core_clk);
         look <= 1'h0;
         trigger_in <= 1'h0;
         repeat (8) @(posedge core_clk);
      end
      for (int k = 0; k < 10 && exp_q.size() > 0; k++)
         @(posedge core_clk);
      if (exp_q.size() > 0)
         bad_count++;
      end_of_test();
   end
endmodule
